// File: flash_write_guard_oneshot.v
// Flash write guard, key unlock, one-shot sense strobe and APB registers
`timescale 1ns/1ps
`include "flash_guard_defs.vh"
module flash_write_guard_oneshot #(
   parameter ADDR_W = 16,
   parameter IRQ_N = 8
) (
   input wire clk,
   input wire sys_rst,
   input wire por_event,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire fl_wr_req,
   input wire [ADDR_W-1:0] fl_addr,
   input wire [7:0] fl_wdata,
   input wire fl_rd_req,
   input wire [IRQ_N-1:0] irq_in,
   input wire [IRQ_N-1:0] irq_ack,
   input wire cpu_irq_en,
   input wire idle_req,
   output reg flash_busy_q,
   output reg flash_prog_q,
   output reg flash_erase_q,
   output reg [ADDR_W-1:0] flash_op_addr_q,
   output reg [7:0] flash_op_data_q,
   output reg sense_en_q,
   output reg row_change_q,
   output reg fault_reset_q,
   output reg idle_q,
   output wire [IRQ_N-1:0] irq_out_q
);
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_PROG = 3'b010;
   localparam [2:0] ST_ERASE = 3'b100;
   localparam integer PROG_INT = `PROG_TIME_CYCLES;
   localparam integer ERASE_INT = `ERASE_TIME_CYCLES;
   localparam integer WAKE_INT = `WAKE_MAX_CYCLES - 1;
   localparam [4:0] PROG_LEN = PROG_INT[4:0];
   localparam [4:0] ERASE_LEN = ERASE_INT[4:0];
   localparam [1:0] WAKE_LEN = WAKE_INT[1:0];

   reg [2:0] state_q;
   reg [4:0] op_cnt_q;
   reg [2:0] program_store_control_q;
   reg bypass_q;
   reg mon_en_q;
   reg mon_rst_en_q;
   reg fault_flag_q;
   reg por_flag_q;
   reg fault_armed_q;
   reg in_rst_q;
   reg [1:0] key_stage_q;
   reg key_lock_q;
   reg [ADDR_W-1:0] last_rd_addr_q;
   reg [1:0] wake_cnt_q;
   reg [IRQ_N-1:0] irq_pending;
   wire [IRQ_N-1:0] irq_ack_gated;

   wire wr_strobe = psel & penable & pwrite;
   wire rd_phase = psel & ~penable & ~pwrite;
   wire mapped = (paddr == `OFS_PROGRAM_STORE_CONTROL) | (paddr == `OFS_FLASH_UNLOCK_KEY) |
      (paddr == `OFS_FLASH_TIMING_SCALE) | (paddr == `OFS_RESET_SOURCE_SELECT) |
      (paddr == `OFS_SUPPLY_MONITOR_CTRL) | (paddr == `OFS_GUARD_STATUS);
   wire op_issue = fl_wr_req & program_store_control_q[`BIT_FLASH_WRITE_ENABLE] & (state_q == ST_IDLE); // [RL9]
   wire guard_ok = mon_en_q & mon_rst_en_q; // [RL1]
   wire key_ok = (key_stage_q == 2'd2) & ~key_lock_q;
   wire any_irq = |(irq_in | irq_pending);

   assign irq_ack_gated = irq_ack;

   pending_hold #(
      .N(IRQ_N)
   ) u_hold (
      .clk(clk),
      .sys_rst(sys_rst),
      .irq_in(irq_in),
      .irq_ack(irq_ack_gated),
      .release_en(~flash_busy_q & cpu_irq_en), // [RL3]
      .irq_pending_q(irq_pending),
      .irq_out_q(irq_out_q)
   );

   // Sticky status survives the fault reset; a reset source select write clears the power-on flag, a later reset the fault flag
   always @(posedge clk) begin
      if (por_event) begin
         mon_en_q <= 1'b1; // [RL2]
         mon_rst_en_q <= 1'b1; // [RL2]
         fault_flag_q <= 1'b0;
         fault_armed_q <= 1'b0;
         in_rst_q <= 1'b0;
         por_flag_q <= 1'b1;
      end else begin
         in_rst_q <= sys_rst;
         if (wr_strobe & pready & (paddr == `OFS_SUPPLY_MONITOR_CTRL))
            mon_en_q <= pwdata[`BIT_SUPPLY_MONITOR_ENABLE];
         if (wr_strobe & pready & (paddr == `OFS_RESET_SOURCE_SELECT)) begin
            mon_rst_en_q <= pwdata[`BIT_MONITOR_RESET_ENABLE];
            por_flag_q <= 1'b0;
         end
         // Fault cause kept until the reset it requested has run
         if (fault_reset_q)
            fault_armed_q <= 1'b1; // [RL14]
         else if (in_rst_q & ~sys_rst)
            fault_armed_q <= 1'b0;
         if (fault_reset_q)
            fault_flag_q <= 1'b1; // [RL14]
         else if (sys_rst)
            fault_flag_q <= fault_armed_q; // [RL14]
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         state_q <= ST_IDLE;
         op_cnt_q <= 5'h00;
         program_store_control_q <= 3'h0;
         bypass_q <= 1'b0; // [RL6]
         key_stage_q <= 2'd0;
         key_lock_q <= 1'b0;
         flash_busy_q <= 1'b0;
         flash_prog_q <= 1'b0;
         flash_erase_q <= 1'b0;
         flash_op_addr_q <= {ADDR_W{1'b0}};
         flash_op_data_q <= 8'h00;
         fault_reset_q <= 1'b0;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         fault_reset_q <= 1'b0;
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         if (wr_strobe & pready) begin
            case (paddr)
               `OFS_PROGRAM_STORE_CONTROL: program_store_control_q <= pwdata[2:0];
               `OFS_FLASH_TIMING_SCALE: bypass_q <= pwdata[`BIT_ONESHOT_BYPASS]; // [RL6]
               `OFS_FLASH_UNLOCK_KEY: begin
                  // Wrong key or sequence locks out until reset
                  if (key_stage_q == 2'd0 && pwdata[7:0] == `KEY_FIRST)
                     key_stage_q <= 2'd1; // [RL12]
                  else if (key_stage_q == 2'd1 && pwdata[7:0] == `KEY_SECOND)
                     key_stage_q <= 2'd2; // [RL12]
                  else
                     key_lock_q <= 1'b1; // [RL12]
               end
               default: ;
            endcase
         end
         if (rd_phase) begin
            case (paddr)
               `OFS_PROGRAM_STORE_CONTROL: prdata <= {29'h0, program_store_control_q};
               `OFS_FLASH_UNLOCK_KEY: prdata <= {30'h0, key_lock_q ? 2'd3 : key_stage_q};
               `OFS_FLASH_TIMING_SCALE: prdata <= {25'h0, bypass_q, 6'h00};
               `OFS_RESET_SOURCE_SELECT: prdata <= {25'h0, fault_flag_q, 4'h0, mon_rst_en_q, por_flag_q};
               `OFS_SUPPLY_MONITOR_CTRL: prdata <= {24'h0, mon_en_q, 7'h00};
               `OFS_GUARD_STATUS: prdata <= {28'h0, row_change_q, idle_q, key_ok, flash_busy_q};
               default: prdata <= 32'h0000_0000;
            endcase
         end
         case (state_q)
            ST_IDLE: begin
               if (op_issue) begin
                  if (!guard_ok || !key_ok) begin
                     fault_reset_q <= 1'b1; // [RL1] [RL15]
                  end else begin
                     flash_busy_q <= 1'b1;
                     flash_op_addr_q <= fl_addr;
                     flash_op_data_q <= fl_wdata;
                     key_stage_q <= 2'd0; // [RL12]
                     if (program_store_control_q[`BIT_PAGE_ERASE_ENABLE]) begin
                        flash_erase_q <= 1'b1; // [RL13]
                        op_cnt_q <= ERASE_LEN;
                        state_q <= ST_ERASE;
                     end else begin
                        flash_prog_q <= 1'b1;
                        op_cnt_q <= PROG_LEN;
                        state_q <= ST_PROG;
                     end
                  end
               end
            end
            ST_PROG, ST_ERASE: begin
               if (op_cnt_q == 5'h01) begin
                  flash_busy_q <= 1'b0;
                  flash_prog_q <= 1'b0;
                  flash_erase_q <= 1'b0;
                  state_q <= ST_IDLE;
               end
               op_cnt_q <= op_cnt_q - 5'h01;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Read side: sense strobe and row tracking
   always @(posedge clk) begin
      if (sys_rst) begin
         sense_en_q <= 1'b1;
         row_change_q <= 1'b0;
         last_rd_addr_q <= {ADDR_W{1'b0}};
      end else begin
         sense_en_q <= bypass_q | fl_rd_req; // [RL5]
         if (fl_rd_req) begin
            last_rd_addr_q <= fl_addr;
            row_change_q <= (fl_addr[ADDR_W-1:`ROW_SHIFT] != last_rd_addr_q[ADDR_W-1:`ROW_SHIFT]); // [RL8]
         end else begin
            row_change_q <= 1'b0;
         end
      end
   end

   // Idle mode with bounded wake-up
   always @(posedge clk) begin
      if (sys_rst) begin
         idle_q <= 1'b0;
         wake_cnt_q <= 2'd0;
      end else if (idle_q) begin
         if (wake_cnt_q != 2'd0) begin
            if (wake_cnt_q == WAKE_LEN)
               idle_q <= 1'b0; // [RL4]
            wake_cnt_q <= wake_cnt_q + 2'd1;
         end else if (any_irq) begin
            wake_cnt_q <= 2'd1; // [RL4]
         end
      end else begin
         wake_cnt_q <= 2'd0;
         idle_q <= idle_req;
      end
   end
endmodule // flash_write_guard_oneshot

// File: flash_guard_defs.vh
// Register offsets, field positions, key values and timing counts for the flash guard
// Notes on behaviour
// [RL1] Write or erase needs monitor and reset-source enable
// [RL2] Power-on reset enables monitor and its reset
// [RL3] Interrupts pending during flash operation are held
// [RL4] Idle wake-up on interrupt within three cycles
// [RL5] One-shot strobes sense amps each accessed cycle
// [RL6] One-shot on after reset; bypass bit disables
// [RL7] Software bypasses one-shot above 10 MHz
// [RL8] Flash rows are 128 bytes; row change flagged
// [RL9] Write enable sits at control bit zero
// [RL10] Reset source written directly, flag bit set
// [RL11] Software uses internal oscillator during flash writes
// [RL12] Unlock by key 0xA5 then 0xF1, single use
// [RL13] Erase enable plus write enable erases page
// [RL14] Fault reset leaves fault flag read as one
// [RL15] Fault check made when operation is issued
`ifndef FLASH_GUARD_DEFS_VH
`define FLASH_GUARD_DEFS_VH
`define OFS_PROGRAM_STORE_CONTROL 12'h000
`define OFS_FLASH_UNLOCK_KEY 12'h004
`define OFS_FLASH_TIMING_SCALE 12'h008
`define OFS_RESET_SOURCE_SELECT 12'h00C
`define OFS_SUPPLY_MONITOR_CTRL 12'h010
`define OFS_GUARD_STATUS 12'h014
`define BIT_FLASH_WRITE_ENABLE 0
`define BIT_PAGE_ERASE_ENABLE 1
`define BIT_SCRATCH_ENABLE 2
`define BIT_ONESHOT_BYPASS 6
`define BIT_POWER_ON_RESET_FLAG 1
`define BIT_MONITOR_RESET_ENABLE 1
`define BIT_FLASH_FAULT_FLAG 6
`define BIT_SUPPLY_MONITOR_ENABLE 7
`define KEY_FIRST 8'hA5
`define KEY_SECOND 8'hF1
`define ROW_BYTES 128
`define ROW_SHIFT 7
`define WAKE_MAX_CYCLES 3
`define ONESHOT_MIN_NS 20
`define CLK_PERIOD_NS 100
`define ONESHOT_CYCLES 1
`define PROG_TIME_CYCLES 4
`define ERASE_TIME_CYCLES 16
`endif

// File: pending_hold.v
// Holds interrupt requests raised while a flash operation runs
`timescale 1ns/1ps
module pending_hold #(
   parameter N = 8
) (
   input wire clk,
   input wire sys_rst,
   input wire [N-1:0] irq_in,
   input wire [N-1:0] irq_ack,
   input wire release_en,
   output reg [N-1:0] irq_pending_q,
   output reg [N-1:0] irq_out_q
);
   genvar i;
   generate
      for (i = 0; i < N; i = i + 1) begin : g_line
         always @(posedge clk) begin
            if (sys_rst) begin
               irq_pending_q[i] <= 1'b0;
               irq_out_q[i] <= 1'b0;
            end else begin
               // Set beats acknowledge
               irq_pending_q[i] <= irq_in[i] | (irq_pending_q[i] & ~irq_ack[i]); // [RL3]
               irq_out_q[i] <= release_en & (irq_in[i] | (irq_pending_q[i] & ~irq_ack[i])); // [RL3]
            end
         end
      end
   endgenerate
endmodule // pending_hold

// File: flash_write_guard_oneshot_properties.sv
// Port checker for the flash guard
`timescale 1ns/1ps
module flash_guard_checker #(
   parameter IRQ_N = 8
) (
   input wire clk,
   input wire sys_rst,
   input wire psel,
   input wire penable,
   input wire pready,
   input wire pslverr,
   input wire fl_wr_req,
   input wire fl_rd_req,
   input wire [IRQ_N-1:0] irq_in,
   input wire flash_busy_q,
   input wire sense_en_q,
   input wire row_change_q,
   input wire fault_reset_q,
   input wire idle_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_apb_ready: assert property (psel && penable |-> pready) else $error("no ready in access");
   a_ready_once: assert property (pready |=> !pready) else $error("ready held too long");
   a_sense_read: assert property (fl_rd_req |=> sense_en_q) else $error("no sense strobe");
   a_row_cause: assert property (row_change_q |-> $past(fl_rd_req)) else $error("row flag without read");
   a_fault_pulse: assert property (fault_reset_q |=> !fault_reset_q) else $error("fault pulse too long");
   a_busy_cause: assert property ($rose(flash_busy_q) |-> $past(fl_wr_req)) else $error("busy no cause");
   a_busy_min: assert property ($rose(flash_busy_q) |-> flash_busy_q [*4]) else $error("busy short");
   a_busy_ends: assert property ($rose(flash_busy_q) |-> ##[4:16] !flash_busy_q) else $error("busy stuck");
   a_wake_bound: assert property (idle_q && (|irq_in) |-> ##[1:3] !idle_q) else $error("slow wake");
   c_fault: cover property (fault_reset_q);
   c_busy: cover property ($rose(flash_busy_q));
   c_refused: cover property (pready && pslverr);
endmodule // flash_guard_checker
bind flash_write_guard_oneshot flash_guard_checker #(.IRQ_N(IRQ_N)) flash_guard_checker_inst (.clk(clk),
   .sys_rst(sys_rst), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .fl_wr_req(fl_wr_req),
   .fl_rd_req(fl_rd_req), .irq_in(irq_in), .flash_busy_q(flash_busy_q), .sense_en_q(sense_en_q),
   .row_change_q(row_change_q), .fault_reset_q(fault_reset_q), .idle_q(idle_q));

// File: cpu_flash_model.sv
// CPU side model issuing flash writes and reads
`timescale 1ns/1ps
module cpu_flash_model (
   input wire clk,
   input wire flash_busy_q,
   output reg fl_wr_req,
   output reg [15:0] fl_addr,
   output reg [7:0] fl_wdata,
   output reg fl_rd_req
);
   initial begin
      fl_wr_req = 1'b0;
      fl_rd_req = 1'b0;
      fl_addr = 16'h0000;
      fl_wdata = 8'h00;
   end
   task automatic wr(input [15:0] a, input [7:0] d); // runs on the single internal clock
      begin
         while (flash_busy_q) @(posedge clk);
         fl_addr <= a;
         fl_wdata <= d;
         fl_wr_req <= 1'b1;
         @(posedge clk);
         fl_wr_req <= 1'b0;
         fl_addr <= ~a;
         fl_wdata <= ~d;
      end
   endtask
   task automatic rd(input [15:0] a);
      begin
         fl_addr <= a;
         fl_rd_req <= 1'b1;
         @(posedge clk);
         fl_rd_req <= 1'b0;
         fl_addr <= ~a;
      end
   endtask
endmodule // cpu_flash_model

// File: flash_write_guard_oneshot_tb_top.sv
// Testbench for the flash guard
`timescale 1ns/1ps
module flash_write_guard_oneshot_tb_top;
   logic clk, sys_rst, por_event, psel, penable, pwrite, pready, pslverr, fl_wr_req, fl_rd_req;
   logic cpu_irq_en, idle_req, flash_busy_q, flash_prog_q, flash_erase_q, sense_en_q;
   logic row_change_q, fault_reset_q, idle_q;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] fl_addr, flash_op_addr_q, a;
   logic [7:0] fl_wdata, flash_op_data_q, irq_in, irq_ack, irq_out_q;
   logic [64:0] expq[$];
   int n_errors = 0;
   int num_checks = 0;
   flash_write_guard_oneshot flash_write_guard_oneshot_inst (.clk(clk), .sys_rst(sys_rst), .por_event(por_event),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fl_wr_req(fl_wr_req), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
      .fl_rd_req(fl_rd_req), .irq_in(irq_in), .irq_ack(irq_ack), .cpu_irq_en(cpu_irq_en), .idle_req(idle_req),
      .flash_busy_q(flash_busy_q), .flash_prog_q(flash_prog_q), .flash_erase_q(flash_erase_q),
      .flash_op_addr_q(flash_op_addr_q), .flash_op_data_q(flash_op_data_q), .sense_en_q(sense_en_q),
      .row_change_q(row_change_q), .fault_reset_q(fault_reset_q), .idle_q(idle_q), .irq_out_q(irq_out_q));
   cpu_flash_model cpu_flash_model_inst (.clk(clk), .flash_busy_q(flash_busy_q), .fl_wr_req(fl_wr_req),
      .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_rd_req(fl_rd_req));
   always #50 clk = ~clk; // 10 MHz, one-shot may stay on
   task automatic chk(input string nm, input [31:0] e, input [31:0] s);
      num_checks++;
      if (s !== e) begin
         n_errors++;
         $display("unexpected %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic results;
      $display("errors %0d checks %0d", n_errors, num_checks);
      if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic apb(input w, input [11:0] ad, input [31:0] d, input [31:0] m, input [31:0] e);
      if (!w) expq.push_back({ad > 12'h014, m, e});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (!pready) @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   always @(posedge clk) begin
      if (psel && penable && pready && !pwrite) begin
         chk("prdata", expq[0][31:0], prdata & expq[0][63:32]);
         chk("pslverr", expq[0][64], pslverr);
         void'(expq.pop_front());
      end
   end
   task automatic op(input [31:0] c, input f);
      int n;
      logic [7:0] d;
      a = 16'($urandom);
      d = 8'($urandom);
      n = c[1] ? 16 : 4;
      apb(1, 12'h000, c, 0, 0);
      apb(1, 12'h004, 32'hA5, 0, 0);
      apb(1, 12'h004, 32'hF1, 0, 0);
      cpu_flash_model_inst.wr(a, d);
      @(negedge clk);
      chk("fault", f, fault_reset_q);
      chk("erase", !f && c[1], flash_erase_q);
      chk("prog", !f && !c[1], flash_prog_q);
      if (!f) chk("addr", a, flash_op_addr_q);
      if (!f && !c[1]) chk("data", d, flash_op_data_q);
      for (int i = 0; i <= n; i++) begin
         chk("busy", !f && i < n, flash_busy_q);
         @(negedge clk);
      end
      @(posedge clk);
   endtask
   initial begin
      #(5000 * 100);
      n_errors++;
      results;
   end
   initial begin
      void'($urandom(32'hFF4E6FEA));
      {clk, penable, pwrite, paddr, pwdata, irq_in, irq_ack, cpu_irq_en, idle_req} = 0;
      {sys_rst, por_event, psel} = 3'b110;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      por_event <= 1'b0;
      apb(0, 12'h00C, 0, 32'h43, 32'h03);
      apb(0, 12'h010, 0, 32'h80, 32'h80);
      apb(0, 12'h008, 0, 32'h40, 0);
      apb(0, 12'h020, 0, 32'hFFFFFFFF, 0);
      op(32'h1, 0);
      op(32'h3, 0);
      apb(1, 12'h008, 32'h40, 0, 0);
      @(negedge clk);
      chk("sense", 1, sense_en_q);
      @(posedge clk);
      apb(1, 12'h008, 0, 0, 0);
      repeat (2) @(negedge clk);
      chk("sense", 0, sense_en_q);
      @(posedge clk);
      cpu_flash_model_inst.rd(a | 16'h007F);
      @(negedge clk);
      chk("sense", 1, sense_en_q);
      @(posedge clk);
      cpu_flash_model_inst.rd((a | 16'h007F) + 16'h0001);
      @(negedge clk);
      chk("row", 1, row_change_q);
      @(posedge clk);
      cpu_flash_model_inst.rd((a | 16'h007F) + 16'h0001);
      @(negedge clk);
      chk("row", 0, row_change_q);
      @(posedge clk);
      idle_req <= 1'b1;
      @(posedge clk);
      idle_req <= 1'b0;
      repeat (2) @(posedge clk);
      irq_in <= 8'h01;
      @(posedge clk);
      irq_in <= 8'h00;
      repeat (3) @(negedge clk);
      chk("idle", 0, idle_q);
      chk("irq", 0, irq_out_q);
      @(posedge clk);
      cpu_irq_en <= 1'b1;
      repeat (2) @(negedge clk);
      chk("irq", 1, irq_out_q);
      @(posedge clk);
      irq_ack <= 8'h01;
      @(posedge clk);
      irq_ack <= 8'h00;
      @(negedge clk);
      chk("irq", 0, irq_out_q);
      @(posedge clk);
      apb(1, 12'h010, 0, 0, 0);
      op(32'h1, 1);
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
      apb(0, 12'h00C, 0, 32'h40, 32'h40);
      apb(1, 12'h00C, 32'h03, 0, 0);
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
      apb(0, 12'h00C, 0, 32'h43, 32'h02);
      repeat (2) @(posedge clk);
      results;
   end
endmodule // flash_write_guard_oneshot_tb_top
